// [hw/ccs_charge_cycle_sequencer.sv]
// charge cycle sequencer with axi4-lite register slave
// What this block does
// - start at 40 percent after high impedance
// - 80 ms hold, then 256 us steps
// - soft-start done once until high impedance
// - all five loops active, dominant one rules
// - short battery current, then fast charge
// - thermal loop limits die to 120 C
// - system limit cuts charge, then supplement
// - regulation voltage programmable 3.5 to 4.44 V
// - terminate after 32 ms taper, enter detection
// - block termination on other loops, 100 mA
// - system stays regulated after termination
// - end-of-charge-allow zero blocks termination, detection
// - new cycle on supply or battery attach
// - recharge on listed events below overvoltage
// - overvoltage stops converter, battery FET on
// - overvoltage fault reported after 1 ms
// - fault cleared by recharge level or hi-z
// - sink one interval, stays high: done
// - low: not-present fault, alternate source/sink
// - repeat until disabled or found, restart
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`include "ccs_consts.svh"
module ccs_charge_cycle_sequencer
#(
   parameter int HOLD_CYC   = `CCS_CYC(`CCS_HOLD_US),
   parameter int STEP_CYC   = `CCS_CYC(`CCS_STEP_US),
   parameter int TERM_CYC   = `CCS_CYC(`CCS_TERM_US),
   parameter int OVP_CYC    = `CCS_CYC(`CCS_OVP_US),
   parameter int DETECT_CYC = `CCS_CYC(`CCS_DETECT_US)
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // axi4-lite write
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // analog comparators
   input  wire logic        supplyValid,
   input  wire logic        chargeDisablePin,
   input  wire logic        batBelowShort,
   input  wire logic        batAboveRecharge,
   input  wire logic        batAboveOvp,
   input  wire logic        batAboveDetect,
   input  wire logic        belowTaperCutoff,
   input  wire logic        nonVoltageLoopActive,
   input  wire logic        supplementEvent,
   // analog controls
   output logic [15:0]      inputLimitEff,
   output logic             softStartDone,
   output logic             loopsEnable,
   output logic             shortCurrentOn,
   output logic             fastChargeOn,
   output logic             chargeFetOn,
   output logic             converterOn,
   output logic             batteryFetOn,
   output logic             sysRegulate,
   output logic             supplementAllow,
   output logic             sinkOn,
   output logic             sourceOn,
   output logic             ovpFault,
   output logic             noBatFault,
   output logic             chargeDoneFlag
);
   initial
   begin
      if (HOLD_CYC < 1 || STEP_CYC < 1 || TERM_CYC < 1 ||
          OVP_CYC < 1 || DETECT_CYC < 1 || HOLD_CYC > 16777215 ||
          DETECT_CYC > 16777215 || TERM_CYC > 16777215 ||
          OVP_CYC > 16777215 || STEP_CYC > 16777215)
         $error("timing count out of range");
   end
   // =====================================================
   // register bus
   logic [31:0] ctrl;
   logic [15:0] limitSet;
   logic [15:0] vregSet;
   logic        awHeld;
   logic        wHeld;
   logic [31:0] awAddr;
   logic [31:0] wData;
   wire         doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire         wrCtrl  = doWrite && awAddr == `CCS_REG_CTRL;
   wire         wrLimit = doWrite && awAddr == `CCS_REG_LIMIT;
   wire         wrVreg  = doWrite && awAddr == `CCS_REG_VREG;
   wire         wrOk    = wrCtrl || wrLimit || wrVreg;
   wire  [15:0] wVolt   = wData[15:0];
   wire  [15:0] vregNew = (wVolt < `CCS_VREG_MIN) ? `CCS_VREG_MIN :
                          (wVolt > `CCS_VREG_MAX) ? `CCS_VREG_MAX : wVolt;
   wire         chgEn   = ctrl[`CCS_CTRL_CHGEN];
   wire         hizBit  = ctrl[`CCS_CTRL_HIZ];
   wire         eocAllow = ctrl[`CCS_CTRL_EOC];
   wire         hiz     = hizBit || chargeDisablePin;

   assign s_axi_awready = !awHeld;
   assign s_axi_wready  = !wHeld;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 32'h0;
         wData <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && !awHeld)
         begin
            awHeld <= 1'b1;
            awAddr <= {s_axi_awaddr[31:2], 2'b00};
         end
         if (s_axi_wvalid && !wHeld)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
         end
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? 2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl <= `CCS_CTRL_RESETVAL;
         limitSet <= `CCS_LIMIT_RESET;
         vregSet <= `CCS_VREG_RESET;
      end
      else
      begin
         if (wrCtrl)
            ctrl <= {28'h0, wData[3:0]};
         if (wrLimit)
            limitSet <= wData[15:0];
         if (wrVreg)
            vregSet <= vregNew;
      end
   end
   // =====================================================
   // soft-start
   logic [7:0]  pct;
   logic        ssHold;
   logic        ssRun;
   wire         holdEnd;
   wire         stepEnd;
   ccs_interval_timer #(.WIDTH(24)) holdTimer
   (
      .clk     (clk),
      .rst     (rst),
      .run     (ssHold && !hiz),
      .span    (24'(HOLD_CYC)),
      .expired (holdEnd)
   );
   ccs_interval_timer #(.WIDTH(24)) stepTimer
   (
      .clk     (clk),
      .rst     (rst),
      .run     (ssRun && !ssHold),
      .span    (24'(STEP_CYC)),
      .expired (stepEnd)
   );
   wire [7:0] next_pct = (pct == 8'h50) ? `CCS_PCT_FULL :
                         8'(pct + `CCS_PCT_STEP);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pct <= `CCS_PCT_START;
         ssHold <= 1'b1;
         ssRun <= 1'b1;
         softStartDone <= 1'b0;
      end
      else if (hiz)
      begin
         pct <= `CCS_PCT_START;
         ssHold <= 1'b1;
         ssRun <= 1'b1;
         softStartDone <= 1'b0;
      end
      else if (holdEnd)
         ssHold <= 1'b0;
      else if (stepEnd)
      begin
         pct <= next_pct;
         if (next_pct == `CCS_PCT_FULL)
         begin
            ssRun <= 1'b0;
            softStartDone <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         inputLimitEff <= 16'h0;
      else
         inputLimitEff <= 16'((32'(limitSet) * 32'(pct)) / 32'd100);
   end
   // =====================================================
   // overvoltage
   logic [23:0] ovpCnt;
   wire        ovpNow = batAboveOvp;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ovpCnt <= 24'h0;
         ovpFault <= 1'b0;
      end
      else
      begin
         ovpCnt <= ovpNow ? ((ovpCnt == 24'(OVP_CYC)) ? ovpCnt :
                   24'(ovpCnt + 24'h1)) : 24'h0;
         if (ovpNow && ovpCnt == 24'(OVP_CYC - 1))
            ovpFault <= 1'b1;
         else if (!batAboveRecharge || hiz)
            ovpFault <= 1'b0;
      end
   end
   // =====================================================
   // charge phases
   ccs_pkg::ccs_phase_t phase;
   ccs_pkg::ccs_phase_t next_phase;
   logic       prevChgEn;
   logic       prevReset;
   logic       prevHiz;
   logic       prevSupply;
   logic       prevBatLow;
   ccs_pkg::ccs_phase_t lastPhase;
   wire        termEnd;
   wire        detEnd;
   wire        termOk = eocAllow && !nonVoltageLoopActive &&
                        limitSet != `CCS_LIMIT_LOW && batAboveRecharge &&
                        belowTaperCutoff && !supplementEvent;
   wire        batLow = !batAboveRecharge;
   wire        newCycle = !chargeDisablePin &&
                          ((supplyValid && !prevSupply && batLow) ||
                           (batLow && !prevBatLow && supplyValid));
   wire        recharge = supplyValid && !batAboveOvp &&
                          ((batLow && !prevBatLow) ||
                           chgEn != prevChgEn ||
                           ctrl[`CCS_CTRL_RESET] != prevReset ||
                           supplementEvent || hiz != prevHiz);
   wire        active = supplyValid && chgEn && !hiz;
   wire        inDetect = phase == ccs_pkg::CCS_SINK ||
                          phase == ccs_pkg::CCS_SOURCE;
   wire        charging = phase == ccs_pkg::CCS_PRE ||
                          phase == ccs_pkg::CCS_FAST ||
                          phase == ccs_pkg::CCS_TAPER;

   ccs_interval_timer #(.WIDTH(24)) termTimer
   (
      .clk     (clk),
      .rst     (rst),
      .run     (phase == ccs_pkg::CCS_TAPER && termOk),
      .span    (24'(TERM_CYC)),
      .expired (termEnd)
   );
   ccs_interval_timer #(.WIDTH(24)) detTimer
   (
      .clk     (clk),
      .rst     (rst),
      .run     (inDetect && phase == lastPhase),
      .span    (24'(DETECT_CYC)),
      .expired (detEnd)
   );

   always_comb
   begin
      next_phase = phase;
      unique case (phase)
         ccs_pkg::CCS_IDLE, ccs_pkg::CCS_DONE:
            if (active && (newCycle || recharge))
               next_phase = batBelowShort ? ccs_pkg::CCS_PRE :
                            ccs_pkg::CCS_FAST;
         ccs_pkg::CCS_PRE:
            if (!batBelowShort)
               next_phase = ccs_pkg::CCS_FAST;
         ccs_pkg::CCS_FAST:
            if (batAboveRecharge)
               next_phase = ccs_pkg::CCS_TAPER;
         ccs_pkg::CCS_TAPER:
            if (termEnd && eocAllow)
               next_phase = ccs_pkg::CCS_SINK;
         ccs_pkg::CCS_SINK:
            if (!batAboveDetect)
               next_phase = ccs_pkg::CCS_SOURCE;
            else if (detEnd)
               next_phase = (noBatFault) ? ccs_pkg::CCS_FAST :
                            ccs_pkg::CCS_DONE;
         ccs_pkg::CCS_SOURCE:
            if (detEnd)
               next_phase = ccs_pkg::CCS_SINK;
      endcase
      if (!active || ovpNow)
         next_phase = ccs_pkg::CCS_IDLE;
      else if (inDetect && !eocAllow)
         next_phase = ccs_pkg::CCS_FAST;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         phase <= ccs_pkg::CCS_IDLE;
         prevChgEn <= 1'b1;
         prevReset <= 1'b0;
         prevHiz <= 1'b0;
         prevSupply <= 1'b0;
         prevBatLow <= 1'b0;
         lastPhase <= ccs_pkg::CCS_IDLE;
      end
      else
      begin
         phase <= next_phase;
         prevChgEn <= chgEn;
         prevReset <= ctrl[`CCS_CTRL_RESET];
         prevHiz <= hiz;
         prevSupply <= supplyValid;
         prevBatLow <= batLow;
         lastPhase <= phase;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         noBatFault <= 1'b0;
         chargeDoneFlag <= 1'b0;
         sourceOn <= 1'b0;
      end
      else
      begin
         if (phase == ccs_pkg::CCS_SINK && !batAboveDetect)
            noBatFault <= 1'b1;
         else if (phase == ccs_pkg::CCS_SINK && detEnd)
            noBatFault <= 1'b0;
         else if (!active)
            noBatFault <= 1'b0;
         sourceOn <= next_phase == ccs_pkg::CCS_SOURCE &&
                     !(phase == ccs_pkg::CCS_SOURCE && batAboveDetect) &&
                     !(sourceOn == 1'b0 && phase == ccs_pkg::CCS_SOURCE);
         chargeDoneFlag <= next_phase == ccs_pkg::CCS_DONE;
      end
   end
   // =====================================================
   // outputs to analog side
   // all loops enabled while charging
   assign loopsEnable = charging;
   assign shortCurrentOn = phase == ccs_pkg::CCS_PRE;
   assign fastChargeOn = phase == ccs_pkg::CCS_FAST ||
                         phase == ccs_pkg::CCS_TAPER;
   assign chargeFetOn = charging && !ovpNow;
   assign converterOn = supplyValid && !hiz && !ovpNow;
   assign batteryFetOn = ovpNow || !supplyValid || hiz || charging;
   assign sysRegulate = converterOn;
   assign supplementAllow = supplyValid && !hiz;
   assign sinkOn = phase == ccs_pkg::CCS_SINK;
   // =====================================================
   // read path
   wire [31:0] rAddr = {s_axi_araddr[31:2], 2'b00};
   wire [31:0] status = {22'h0, 3'(phase), chargeDoneFlag, noBatFault,
                         ovpFault, softStartDone, sourceOn, sinkOn,
                         chargeFetOn};
   wire        rHit = rAddr <= `CCS_REG_EFFLIM;
   wire [31:0] rVal = (rAddr == `CCS_REG_CTRL)   ? ctrl :
                      (rAddr == `CCS_REG_LIMIT)  ? {16'h0, limitSet} :
                      (rAddr == `CCS_REG_VREG)   ? {16'h0, vregSet} :
                      (rAddr == `CCS_REG_STATUS) ? status :
                      (rAddr == `CCS_REG_EFFLIM) ? {16'h0, inputLimitEff} :
                      32'h0;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rVal;
         s_axi_rresp <= rHit ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   // =====================================================
   // checks
   sequence ovpHeld;
      batAboveOvp [*8];
   endsequence
   ovp_stop_a: assert property (@(posedge clk) disable iff (rst)
      batAboveOvp |-> !converterOn && batteryFetOn)
      else $error("converter not stopped on overvoltage");
   ovp_fault_a: assert property (@(posedge clk) disable iff (rst)
      $rose(ovpFault) |-> $past(batAboveOvp))
      else $error("overvoltage fault without condition");
   ovp_clear_a: assert property (@(posedge clk) disable iff (rst)
      hiz && !batAboveOvp |=> !ovpFault)
      else $error("overvoltage fault not cleared");
   ss_start_a: assert property (@(posedge clk) disable iff (rst)
      hiz |=> pct == `CCS_PCT_START && !softStartDone)
      else $error("soft-start not restarted");
   ss_done_a: assert property (@(posedge clk) disable iff (rst)
      $rose(softStartDone) |-> pct == `CCS_PCT_FULL)
      else $error("soft-start done early");
   term_block_a: assert property (@(posedge clk) disable iff (rst)
      !eocAllow |=> !inDetect)
      else $error("detection while end of charge blocked");
   short_cur_a: assert property (@(posedge clk) disable iff (rst)
      phase == ccs_pkg::CCS_PRE && !batBelowShort && active && !ovpNow
      |=> phase == ccs_pkg::CCS_FAST)
      else $error("fast charge not entered");
   det_fault_a: assert property (@(posedge clk) disable iff (rst)
      sinkOn && !batAboveDetect && active |=> noBatFault)
      else $error("not-present fault missing");
endmodule

// [hw/ccs_consts.svh]
// timing, step and register constants for the charge cycle sequencer
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH
// =====================================================
// clock and times
`define CCS_CLK_HZ          20000000
`define CCS_HOLD_US         80000
`define CCS_STEP_US         256
`define CCS_TERM_US         32000
`define CCS_OVP_US          1000
`define CCS_DETECT_US       250000
`define CCS_CYC(us)         (((us) * (`CCS_CLK_HZ / 1000000)))
// =====================================================
// soft-start percentages
`define CCS_PCT_START       8'h28
`define CCS_PCT_FULL        8'h64
`define CCS_PCT_STEP        8'h0a
// =====================================================
// register byte offsets
`define CCS_REG_CTRL        32'h00
`define CCS_REG_LIMIT       32'h04
`define CCS_REG_VREG        32'h08
`define CCS_REG_STATUS      32'h0c
`define CCS_REG_EFFLIM      32'h10
// control field positions
`define CCS_CTRL_CHGEN      0
`define CCS_CTRL_RESET      1
`define CCS_CTRL_HIZ        2
`define CCS_CTRL_EOC        3
`define CCS_CTRL_RESETVAL   32'h0000_000d
// regulation voltage in mV, input limits in mA
`define CCS_VREG_MIN        16'h0dac
`define CCS_VREG_MAX        16'h1158
`define CCS_VREG_RESET      16'h0e10
`define CCS_LIMIT_RESET     16'h05dc
`define CCS_LIMIT_LOW       16'h0064
`endif

// [hw/ccs_pkg.sv]
// types of the charge cycle sequencer
package ccs_pkg;
   typedef enum logic [2:0]
   {
      CCS_IDLE,
      CCS_PRE,
      CCS_FAST,
      CCS_TAPER,
      CCS_SINK,
      CCS_SOURCE,
      CCS_DONE
   } ccs_phase_t;
endpackage

// [hw/ccs_interval_timer.sv]
// reloadable interval counter with one-cycle expiry pulse
module ccs_interval_timer
#(
   parameter int WIDTH = 24
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // control
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] span,
   // result
   output logic                  expired
);
   logic [WIDTH-1:0] count;
   wire              atEnd = (count == span - {{(WIDTH-1){1'b0}}, 1'b1});

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count <= '0;
      else if (!run || atEnd)
         count <= '0;
      else
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
   end

   assign expired = run && atEnd;
endmodule

// [testbench/ccs_battery_model.sv]
// battery pack model feeding the analog comparator inputs
module ccs_battery_model
#(
   parameter int SHORT_MV  = 2000,
   parameter int RCH_MV    = 100,
   parameter int DETECT_MV = 2500
)
(
   // pack state from the bench
   input  wire logic [15:0] batMv,
   input  wire logic [15:0] vregMv,
   input  wire logic        present,
   // detection source current
   input  wire logic        sourceOn,
   // comparators
   output logic             batBelowShort,
   output logic             batAboveRecharge,
   output logic             batAboveOvp,
   output logic             batAboveDetect
);
   timeunit 1ns;
   timeprecision 100ps;
   assign batBelowShort    = batMv < SHORT_MV;
   assign batAboveRecharge = batMv > vregMv - RCH_MV;
   assign batAboveOvp      = batMv * 100 > vregMv * 105;
   // empty slot: the source alone lifts the pin to the detect level
   assign batAboveDetect   = present ? (batMv >= DETECT_MV) : sourceOn;
endmodule

// [testbench/ccs_charge_cycle_sequencer_tb_top.sv]
// self-checking bench for the charge cycle sequencer
module ccs_charge_cycle_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD_C = 20;
   localparam int STEP_C = 8;
   localparam int TERM_C = 16;
   localparam int OVP_C  = 10;
   localparam int DET_C  = 16;
   localparam int LIMIT  = 3000;
   // =====================================================
   // signals
   logic        clk = 1'b0, rst = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1, supplyValid = 1'b1;
   logic        chargeDisablePin = 1'b0, belowTaperCutoff = 1'b0;
   logic        nonVoltageLoopActive = 1'b0, supplementEvent = 1'b0;
   logic        present = 1'b1;
   logic [15:0] batMv = 16'hbb8, vregMv = 16'he10, inputLimitEff;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, batBelowShort;
   logic        batAboveRecharge, batAboveOvp, batAboveDetect;
   logic        softStartDone, loopsEnable, shortCurrentOn, fastChargeOn;
   logic        chargeFetOn, converterOn, batteryFetOn, sysRegulate;
   logic        supplementAllow, sinkOn, sourceOn, ovpFault, noBatFault;
   logic        chargeDoneFlag;
   logic [31:0] vIn [3] = '{32'hbb8, 32'h1388, 32'h1068};
   logic [31:0] vOut [3] = '{32'hdac, 32'h1158, 32'h1068};
   logic [15:0] steps [5] = '{16'h1f4, 16'h258, 16'h2bc, 16'h320, 16'h3e8};
   int          n_fail = 0, n_tests = 0, cycles = 0, n;
   always #25 clk = ~clk;
   // =====================================================
   // design and pack
   ccs_charge_cycle_sequencer
   #(
      .HOLD_CYC(HOLD_C), .STEP_CYC(STEP_C), .TERM_CYC(TERM_C),
      .OVP_CYC(OVP_C), .DETECT_CYC(DET_C)
   )
   dut
   (
      .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .supplyValid, .chargeDisablePin,
      .batBelowShort, .batAboveRecharge, .batAboveOvp, .batAboveDetect,
      .belowTaperCutoff, .nonVoltageLoopActive, .supplementEvent,
      .inputLimitEff, .softStartDone, .loopsEnable, .shortCurrentOn,
      .fastChargeOn, .chargeFetOn, .converterOn, .batteryFetOn,
      .sysRegulate, .supplementAllow, .sinkOn, .sourceOn, .ovpFault,
      .noBatFault, .chargeDoneFlag
   );
   ccs_battery_model batModel
   (
      .batMv, .vregMv, .present, .sourceOn, .batBelowShort,
      .batAboveRecharge, .batAboveOvp, .batAboveDetect
   );
   // =====================================================
   // bus tasks and checks
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      rsp = s_axi_bresp;
   endtask
   task automatic rdr(input logic [31:0] a);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic at(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_tests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                  got, exp);
         n_fail++;
      end
   endtask
   task automatic summarize();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         $display("CHECK FAILED at %0t: timeout", $time);
         n_fail++;
         summarize();
      end
   end
   // =====================================================
   // test sequence
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdr(32'h0);
      chk(rd, 32'hd, "ctrl reset");
      rdr(32'h4);
      chk(rd, 32'h5dc, "limit reset");
      rdr(32'h40);
      chk({rd[29:0], rsp}, 32'h2, "unmapped read");
      wr(32'h40, 32'h1);
      chk(rsp, 2'h2, "unmapped write");
      // still in high impedance while the voltage changes
      foreach (vIn[i])
      begin
         wr(32'h8, vIn[i]);
         rdr(32'h8);
         chk(rd, vOut[i], "vreg clamp");
      end
      vregMv <= 16'h1068;
      wr(32'h4, 32'h3e8);
      batMv <= 16'h5dc;
      wr(32'h0, 32'h9);
      at(1);
      chk(inputLimitEff, 16'h190, "start level");
      chk(softStartDone, 1'b0, "early done");
      chk(shortCurrentOn, 1'b1, "short current");
      chk(loopsEnable, 1'b1, "loops on");
      foreach (steps[i])
      begin
         n = 0;
         rd = inputLimitEff;
         while (inputLimitEff === rd[15:0])
         begin
            at(0);
            n++;
         end
         chk(inputLimitEff, steps[i], "step value");
         chk(n > (i ? STEP_C - 2 : HOLD_C + STEP_C - 3) &&
             n < (i ? STEP_C + 2 : HOLD_C + STEP_C + 2), 1, "step time");
      end
      at(0);
      chk(softStartDone, 1'b1, "soft start done");
      @(posedge clk);
      batMv <= 16'hdac;
      at(1);
      chk({shortCurrentOn, fastChargeOn}, 2'h1, "fast charge");
      @(posedge clk);
      batMv <= 16'h1036;
      belowTaperCutoff <= 1'b1;
      nonVoltageLoopActive <= 1'b1;
      at(3 * TERM_C);
      chk(chargeFetOn, 1'b1, "blocked by loop");
      @(posedge clk);
      nonVoltageLoopActive <= 1'b0;
      wr(32'h4, 32'h64);
      at(3 * TERM_C);
      chk(chargeFetOn, 1'b1, "blocked by limit");
      wr(32'h4, 32'h3e8);
      wr(32'h0, 32'h1);
      at(3 * TERM_C);
      chk({chargeFetOn, sinkOn}, 2'h2, "blocked by allow bit");
      wr(32'h0, 32'h9);
      at(TERM_C + 3);
      chk({chargeFetOn, sinkOn}, 2'h1, "terminated");
      chk({sysRegulate, supplementAllow}, 2'h3, "system kept");
      at(DET_C + 2);
      chk({chargeDoneFlag, noBatFault}, 2'h2, "pack found");
      @(posedge clk);
      present <= 1'b0;
      wr(32'h0, 32'hd);
      wr(32'h0, 32'h9);
      while (sourceOn !== 1'b1)
         at(0);
      chk(noBatFault, 1'b1, "no pack fault");
      at(2);
      chk(sourceOn, 1'b0, "source cut early");
      @(posedge clk);
      present <= 1'b1;
      belowTaperCutoff <= 1'b0;
      while (noBatFault !== 1'b0)
         at(0);
      at(1);
      chk(fastChargeOn, 1'b1, "new cycle");
      @(posedge clk);
      batMv <= 16'h1194;
      at(0);
      chk({converterOn, batteryFetOn}, 2'h1, "overvoltage");
      chk(ovpFault, 1'b0, "deglitch");
      at(OVP_C + 2);
      chk(ovpFault, 1'b1, "fault report");
      @(posedge clk);
      batMv <= 16'hdac;
      at(3);
      chk(ovpFault, 1'b0, "fault clear");
      summarize();
   end
endmodule
